// ---- spk_pkg.sv ----
// Constants and carrier types for the serial printer-keyboard control unit
package spk_pkg;

	// Register bus: addresses and data width
	localparam int unsigned ADDR_W   = 4;
	localparam int unsigned DATA_W   = 16;
	localparam logic [3:0]  ADR_CTL  = 4'h0;
	localparam logic [3:0]  ADR_DOUT = 4'h4;
	localparam logic [3:0]  ADR_DIN  = 4'h8;

	// Control write fields: channel assignment plus a clear and a set bit per flag
	localparam int unsigned CHAN_LSB = 0;
	localparam int unsigned CHAN_W   = 3;
	localparam int unsigned TXB_CLR  = 3;
	localparam int unsigned TXB_SET  = 4;
	localparam int unsigned TXF_CLR  = 5;
	localparam int unsigned TXF_SET  = 6;
	localparam int unsigned RXB_CLR  = 7;
	localparam int unsigned RXB_SET  = 8;
	localparam int unsigned RXF_CLR  = 9;
	localparam int unsigned RXF_SET  = 10;

	// Status read fields
	localparam int unsigned ST_TXB   = 3;
	localparam int unsigned ST_TXF   = 4;
	localparam int unsigned ST_RXB   = 5;
	localparam int unsigned ST_RXF   = 6;

	// Character and line format
	localparam int unsigned CHAR_W   = 8;
	localparam logic [7:0]  SHIFT_LAST = 8'h01;
	localparam logic [7:0]  SHIFT_ZERO = 8'h00;
	localparam logic [2:0]  STOP_FULL  = 3'h4;
	localparam logic [2:0]  STOP_START = 3'h1;
	localparam logic [2:0]  STOP_ONE   = 3'h1;
	localparam logic [2:0]  CHAN_NONE  = 3'h0;

	// Timing: line rate and tick rates per bit unit
	localparam int unsigned SYS_CLK_HZ     = 100_000_000;
	localparam int unsigned LINE_BAUD      = 110;
	localparam int unsigned TX_TICKS_UNIT  = 2;
	localparam int unsigned RX_TICKS_UNIT  = 8;
	localparam int unsigned TX_TICK_CYC    = SYS_CLK_HZ / (LINE_BAUD * TX_TICKS_UNIT);
	localparam int unsigned RX_TICK_CYC    = SYS_CLK_HZ / (LINE_BAUD * RX_TICKS_UNIT);
	localparam int unsigned DIV_W          = 20;
	localparam logic [19:0] DIV_ONE        = 20'h00001;
	localparam logic [19:0] DIV_ZERO       = 20'h00000;

	// Register bus request as it arrives from the processor side
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} spk_bus_req_t;

endpackage : spk_pkg

// ---- spk_printer_model.sv ----
// Keyboard-printer partner: decodes the printer line and plays keystrokes into the receiver side
module spk_printer_model
	import spk_pkg::*;
#(
	parameter int unsigned TX_DIV = 8
)
(
	// Clock
	input  wire logic              sys_clk,
	// Printer side
	input  wire logic              txLine,
	output logic [CHAR_W-1:0]      prChar,
	output logic                   prStrobe,
	output int unsigned            frameGap,
	// Keyboard side
	input  wire logic              rxDataTaken,
	output logic                   rxActive,
	output logic                   rxDone,
	output logic [CHAR_W-1:0]      rxChar
);
	timeunit 1ns;
	timeprecision 1ps;

	time tStart = 0;

	// Samples mid-unit so that a line edge a cycle early or late still decodes
	initial
	begin
		prStrobe = 1'b0;
		prChar   = '0;
		frameGap = 0;
		rxActive = 1'b0;
		rxDone   = 1'b0;
		rxChar   = 8'h5a;
		forever
		begin
			@(negedge txLine);
			frameGap = 32'(($time - tStart) / 10);
			tStart   = $time;
			repeat (TX_DIV) @(posedge sys_clk);
			for (int i = 0; i < CHAR_W; i++)
			begin
				repeat (2 * TX_DIV) @(posedge sys_clk);
				prChar[i] = txLine;
			end
			repeat (2 * TX_DIV) @(posedge sys_clk);
			if (txLine !== 1'b1)
				prChar = 'x;
			prStrobe <= 1'b1;
			@(posedge sys_clk);
			prStrobe <= 1'b0;
		end
	end

	// Key strike: data lines not yet valid show the inverse of the character
	task automatic press(input logic [CHAR_W-1:0] c);
		@(posedge sys_clk);
		rxActive <= 1'b1;
		rxChar   <= ~c;
	endtask

	task automatic land(input logic [CHAR_W-1:0] c);
		@(posedge sys_clk);
		rxChar   <= c;
		rxDone   <= 1'b1;
		rxActive <= 1'b0;
	endtask

	always @(posedge sys_clk)
		if (rxDataTaken)
		begin
			rxDone <= 1'b0;
			rxChar <= ~rxChar;
		end
endmodule // spk_printer_model

// ---- spk_serial_ctrl.sv ----
// Printer-keyboard control unit: control register, interrupt request and serial transmitter
//
// Local design decisions: strobed register access and the register addresses.
module spk_serial_ctrl
	import spk_pkg::*;
#(
	parameter int unsigned TX_DIV = TX_TICK_CYC,
	parameter int unsigned RX_DIV = RX_TICK_CYC
)
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Register bus
	input  wire spk_bus_req_t        busReq,
	output logic [DATA_W-1:0]        rdData,
	// Receiver side
	input  wire logic                rxActive,
	input  wire logic                rxDone,
	input  wire logic [CHAR_W-1:0]   rxChar,
	output logic                     rxSampleTick,
	output logic                     rxDataTaken,
	// Printer line and interrupt request lines 1 to 7
	output logic                     txLine,
	output logic [7:1]               piReq
);

	// Divider step shared by both tick generators
	function automatic logic [DIV_W-1:0] divNext(input logic [DIV_W-1:0] cnt,
		input logic [DIV_W-1:0] top);
		divNext = (cnt >= top - DIV_ONE) ? DIV_ZERO : cnt + DIV_ONE;
	endfunction

	// Control register
	logic [CHAN_W-1:0] piChanAssign_r;
	logic              txBusy_r;
	logic              txFlag_r;
	logic              rxBusy_r;
	logic              rxFlag_r;
	logic              rxActPrev_r;
	logic              rxDonePrev_r;
	logic [DATA_W-1:0] rdData_r;
	logic              rxDataTaken_r;
	logic [7:1]        piReq_r;

	// Tick dividers and transmitter
	logic [DIV_W-1:0]  txDivCnt_r;
	logic [DIV_W-1:0]  rxDivCnt_r;
	logic              txTick_r;
	logic              rxSampleTick_r;
	logic              txEnable_r;
	logic [7:0]        shiftBits_r;
	logic              txLine_r;
	logic              txActive_r;
	logic              halfUnit_r;
	logic [2:0]        stopCnt_r;
	logic              txDone_r;

	// Bus decode
	wire               ctlWr     = busReq.wr && (busReq.addr == ADR_CTL);
	wire               doutWr    = busReq.wr && (busReq.addr == ADR_DOUT);
	wire               dinRd     = busReq.rd && (busReq.addr == ADR_DIN);
	wire               ctlRd     = busReq.rd && (busReq.addr == ADR_CTL);
	wire [DATA_W-1:0]  wd        = busReq.wdata;

	// Events from transmitter and receiver
	wire               txDoneSet = txTick_r && txActive_r && halfUnit_r
		&& (shiftBits_r == SHIFT_LAST);
	wire               rxActRise = rxActive && !rxActPrev_r;
	wire               rxDoneRise = rxDone && !rxDonePrev_r;

	// Transmitter controls
	wire               startChar = txTick_r && !txActive_r && txEnable_r
		&& (stopCnt_r == STOP_FULL);
	wire               shiftNow  = txTick_r && txActive_r && halfUnit_r;
	wire               stopCount = txTick_r && !txActive_r && (stopCnt_r != STOP_FULL);

	// Next values of the control bits; hardware set wins over any software clear
	wire [CHAN_W-1:0]  chanNxt   = ctlWr ? wd[CHAN_LSB +: CHAN_W] : piChanAssign_r;
	wire               txBusyNxt = (doutWr || (ctlWr && wd[TXB_SET]))
		|| (txBusy_r && !txDoneSet && !(ctlWr && wd[TXB_CLR]));
	wire               txFlagNxt = txDoneSet || (ctlWr && wd[TXF_SET])
		|| (txFlag_r && !doutWr && !(ctlWr && wd[TXF_CLR]));
	wire               rxBusyNxt = (rxActRise && !rxDoneRise) || (ctlWr && wd[RXB_SET])
		|| (rxBusy_r && !rxDoneRise && !(ctlWr && wd[RXB_CLR]));
	wire               rxFlagNxt = rxDoneRise || (ctlWr && wd[RXF_SET])
		|| (rxFlag_r && !dinRd && !(ctlWr && wd[RXF_CLR]));

	// Read mux; unmapped addresses read as zero
	wire [DATA_W-1:0]  statusWord = {{(DATA_W-7){1'b0}}, rxFlag_r, rxBusy_r,
		txFlag_r, txBusy_r, piChanAssign_r};
	wire [DATA_W-1:0]  rdNxt     = ctlRd ? statusWord
		: dinRd ? {{(DATA_W-CHAR_W){1'b0}}, rxChar}
		: {DATA_W{1'b0}};

	// Channel decoder gated by either flag
	wire               piGate    = txFlag_r || rxFlag_r;
	wire [7:0]         piOneHot  = 8'h01 << piChanAssign_r;
	wire [7:1]         piReqNxt  = piGate ? piOneHot[7:1] : 7'h00;

	// Control register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			piChanAssign_r <= CHAN_NONE;
			txBusy_r <= 1'b0;
			txFlag_r <= 1'b0;
			rxBusy_r <= 1'b0;
			rxFlag_r <= 1'b0;
		end
		else
		begin
			piChanAssign_r <= chanNxt;
			txBusy_r <= txBusyNxt;
			txFlag_r <= txFlagNxt;
			rxBusy_r <= rxBusyNxt;
			rxFlag_r <= rxFlagNxt;
		end
	end

	// Edge detectors on receiver signals; receiver shares this clock
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxActPrev_r  <= 1'b0;
			rxDonePrev_r <= 1'b0;
		end
		else
		begin
			rxActPrev_r  <= rxActive;
			rxDonePrev_r <= rxDone;
		end
	end

	// Read data one cycle after the strobe; data-input read also tells the receiver
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rdData_r      <= {DATA_W{1'b0}};
			rxDataTaken_r <= 1'b0;
		end
		else
		begin
			rdData_r      <= rdNxt;
			rxDataTaken_r <= dinRd;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			piReq_r <= 7'h00;
		else
			piReq_r <= piReqNxt;
	end

	// Tick dividers replace the crystal countdown chain
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txDivCnt_r     <= DIV_ZERO;
			rxDivCnt_r     <= DIV_ZERO;
			txTick_r       <= 1'b0;
			rxSampleTick_r <= 1'b0;
		end
		else
		begin
			txDivCnt_r     <= divNext(txDivCnt_r, DIV_W'(TX_DIV));
			rxDivCnt_r     <= divNext(rxDivCnt_r, DIV_W'(RX_DIV));
			txTick_r       <= (txDivCnt_r == DIV_ZERO);
			rxSampleTick_r <= (rxDivCnt_r == DIV_ZERO);
		end
	end

	// Enable flip-flop: set by data-output, cleared by the first shift
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			txEnable_r <= 1'b0;
		else if (doutWr)
			txEnable_r <= 1'b1;
		else if (shiftNow)
			txEnable_r <= 1'b0;
	end

	// Shift chain: enable -> bits 8..1 -> line; bit 1 holds the first character bit.
	// A data-output during a character overwrites the buffer; software must wait for flag.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			shiftBits_r <= SHIFT_ZERO;
		else if (doutWr)
			shiftBits_r <= wd[CHAR_W-1:0];
		else if (shiftNow)
			shiftBits_r <= {txEnable_r, shiftBits_r[7:1]};
	end

	// Line level: idle marks, start is a space, then data bits, then stop marks
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			txLine_r <= 1'b1;
		else if (startChar)
			txLine_r <= 1'b0;
		else if (shiftNow)
			txLine_r <= shiftBits_r[0];
	end

	// Active and divide-by-two stage
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			txActive_r <= 1'b0;
			halfUnit_r <= 1'b0;
		end
		else if (startChar)
		begin
			txActive_r <= 1'b1;
			halfUnit_r <= 1'b0;
		end
		else if (txTick_r && txActive_r)
		begin
			halfUnit_r <= !halfUnit_r;
			if (txDoneSet)
				txActive_r <= 1'b0;
		end
	end

	// Stop timer: counts ticks after a character and holds at full count
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			stopCnt_r <= STOP_FULL;
		else if (txDoneSet)
			stopCnt_r <= STOP_START;
		else if (stopCount)
			stopCnt_r <= stopCnt_r + STOP_ONE;
	end

	// Done flip-flop: set as active clears, cleared by the next data-output
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			txDone_r <= 1'b1;
		else if (txDoneSet)
			txDone_r <= 1'b1;
		else if (doutWr)
			txDone_r <= 1'b0;
	end

	assign rdData       = rdData_r;
	assign rxSampleTick = rxSampleTick_r;
	assign rxDataTaken  = rxDataTaken_r;
	assign txLine       = txLine_r;
	assign piReq        = piReq_r;

	// Checks on the control register
	property p_ctlLoad;
		@(posedge sys_clk) disable iff (rst)
		ctlWr |=> (piChanAssign_r == $past(wd[CHAN_LSB +: CHAN_W]));
	endproperty
	a_ctlLoad: assert property (p_ctlLoad) else $error("channel field not loaded");

	property p_doutSetsBusy;
		@(posedge sys_clk) disable iff (rst)
		doutWr && !txDoneSet |=> txBusy_r && !txFlag_r;
	endproperty
	a_doutSetsBusy: assert property (p_doutSetsBusy) else $error("data out missed busy");

	property p_doneSetsFlag;
		@(posedge sys_clk) disable iff (rst)
		txDoneSet && !doutWr && !ctlWr |=> !txBusy_r && txFlag_r && txDone_r;
	endproperty
	a_doneSetsFlag: assert property (p_doneSetsFlag) else $error("tx done flag wrong");

	property p_rxActBusy;
		@(posedge sys_clk) disable iff (rst)
		rxActRise && !rxDoneRise && !ctlWr |=> rxBusy_r;
	endproperty
	a_rxActBusy: assert property (p_rxActBusy) else $error("rx busy not set");

	property p_rxDoneFlag;
		@(posedge sys_clk) disable iff (rst)
		rxDoneRise && !ctlWr |=> rxFlag_r && !rxBusy_r;
	endproperty
	a_rxDoneFlag: assert property (p_rxDoneFlag) else $error("rx done flag wrong");

	property p_piQuiet;
		@(posedge sys_clk) disable iff (rst)
		!(txFlag_r || rxFlag_r) || (piChanAssign_r == CHAN_NONE) |=> (piReq_r == 7'h00);
	endproperty
	a_piQuiet: assert property (p_piQuiet) else $error("request without flag");

	property p_piLine;
		@(posedge sys_clk) disable iff (rst)
		txFlag_r && (piChanAssign_r == 3'h5) |=> (piReq_r == 7'h10);
	endproperty
	a_piLine: assert property (p_piLine) else $error("wrong request line");

	// Checks on the transmitter
	property p_start;
		@(posedge sys_clk) disable iff (rst)
		startChar |=> txActive_r && !txLine_r;
	endproperty
	a_start: assert property (p_start) else $error("start unit not sent");

	property p_firstShift;
		@(posedge sys_clk) disable iff (rst)
		shiftNow && !doutWr |=> !txEnable_r && (shiftBits_r[7] == $past(txEnable_r));
	endproperty
	a_firstShift: assert property (p_firstShift) else $error("shift chain wrong");

	property p_stopBegin;
		@(posedge sys_clk) disable iff (rst)
		txDoneSet && !doutWr |=> !txActive_r && txLine_r
			&& (shiftBits_r == SHIFT_ZERO) && (stopCnt_r == STOP_START);
	endproperty
	a_stopBegin: assert property (p_stopBegin) else $error("stop not begun");

	property p_stopHold;
		@(posedge sys_clk) disable iff (rst)
		!txActive_r && (stopCnt_r != STOP_FULL) |=> !txActive_r && txLine_r;
	endproperty
	a_stopHold: assert property (p_stopHold) else $error("stop cut short");

	property p_timerHold;
		@(posedge sys_clk) disable iff (rst)
		(stopCnt_r == STOP_FULL) && !txDoneSet |=> (stopCnt_r == STOP_FULL);
	endproperty
	a_timerHold: assert property (p_timerHold) else $error("stop timer left full count");

	property p_doutLoad;
		@(posedge sys_clk) disable iff (rst)
		doutWr && !txDoneSet |=> txEnable_r && !txDone_r
			&& (shiftBits_r == $past(wd[CHAR_W-1:0]));
	endproperty
	a_doutLoad: assert property (p_doutLoad) else $error("data out not loaded");

	property p_markIdle;
		@(posedge sys_clk) disable iff (rst)
		!txActive_r && !startChar |=> txLine_r;
	endproperty
	a_markIdle: assert property (p_markIdle) else $error("idle line not marking");

	// The receiver relies on this pulse to drop its done level
	property p_dinTaken;
		@(posedge sys_clk) disable iff (rst)
		dinRd && !rxDoneRise && !ctlWr |=> !rxFlag_r && rxDataTaken_r;
	endproperty
	a_dinTaken: assert property (p_dinTaken) else $error("data in not taken");

endmodule // spk_serial_ctrl

// ---- spk_serial_ctrl_tb.sv ----
// Self-checking bench for the printer-keyboard control unit
module spk_serial_ctrl_tb
	import spk_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned TXD = 8;
	logic              sys_clk;
	logic              rst;
	spk_bus_req_t      busReq;
	logic [DATA_W-1:0] rdData;
	logic              rxActive, rxDone, rxSampleTick, rxDataTaken, txLine;
	logic [CHAR_W-1:0] rxChar, prChar, c;
	logic [7:1]        piReq;
	logic              prStrobe;
	int unsigned       frameGap;
	logic              rdPend = 1'b0;
	int                ticks = 0;
	int                errors = 0;
	int                compares = 0;
	int                n, k;
	logic [31:0]       seed;
	logic [15:0]       rdQ[$];
	logic [15:0]       txQ[$];

	spk_serial_ctrl #(.TX_DIV(TXD), .RX_DIV(2)) spk_serial_ctrl_inst (.sys_clk(sys_clk),
		.rst(rst), .busReq(busReq), .rdData(rdData), .rxActive(rxActive), .rxDone(rxDone),
		.rxChar(rxChar), .rxSampleTick(rxSampleTick), .rxDataTaken(rxDataTaken),
		.txLine(txLine), .piReq(piReq));

	spk_printer_model #(.TX_DIV(TXD)) spk_printer_model_inst (.sys_clk(sys_clk),
		.txLine(txLine), .prChar(prChar), .prStrobe(prStrobe), .frameGap(frameGap),
		.rxDataTaken(rxDataTaken), .rxActive(rxActive), .rxDone(rxDone), .rxChar(rxChar));

	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction

	// Status word: flags {rxFlag, rxBusy, txFlag, txBusy} above the channel
	function automatic logic [15:0] st(input logic [2:0] ch, input logic [3:0] f);
		return {9'h000, f, ch};
	endfunction

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		busReq <= '0;
	endtask

	// The read result is checked by the monitor from the queue
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		rdQ.push_back(e);
		@(posedge sys_clk);
		busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		busReq <= '0;
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		if (rdPend)
			check(rdData, rdQ.pop_front());
		if (prStrobe)
			check({8'h00, prChar}, txQ.pop_front());
		rdPend <= busReq.rd;
		if (rxSampleTick)
			ticks <= ticks + 1;
	end

	initial
	begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		wrap_up();
	end

	initial
	begin
		rst = 1'b1;
		busReq = '0;
		seed = 32'd20459;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ADR_CTL, 16'h0000);
		check(16'(txLine), 16'h0001);
		$display("test reset done");
		for (int ch = 0; ch < 8; ch++)
		begin
			wr(ADR_CTL, 16'h0040 | 16'(ch));
			repeat (2) @(posedge sys_clk);
			check(16'(piReq), (ch == 0) ? 16'h0000 : 16'(1 << (ch - 1)));
			rd(ADR_CTL, st(3'(ch), 4'h2));
		end
		wr(ADR_CTL, 16'h0502);
		rd(ADR_CTL, st(3'h2, 4'he));
		wr(ADR_CTL, 16'h00a0);
		rd(ADR_CTL, st(3'h0, 4'h8));
		repeat (2) @(posedge sys_clk);
		check(16'(piReq), 16'h0000);
		rd(4'hc, 16'h0000);
		n = ticks;
		repeat (40) @(posedge sys_clk);
		check(16'(ticks - n), 16'd20);
		$display("test control done");
		wr(ADR_CTL, 16'h0201);
		c = 8'hff;
		for (int i = 0; i < 3; i++)
		begin
			txQ.push_back({8'h00, c});
			wr(ADR_DOUT, {8'h00, c});
			rd(ADR_CTL, st(3'h1, 4'h1));
			k = 0;
			while (piReq[1] !== 1'b1 && k < 1000)
			begin
				@(posedge sys_clk);
				k++;
			end
			if (k == 1000)
			begin
				errors++;
				wrap_up();
			end
			rd(ADR_CTL, st(3'h1, 4'h2));
			c = xs() | 8'h80;
		end
		k = 0;
		while (txQ.size() != 0 && k < 1000)
		begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 1000)
		begin
			errors++;
			wrap_up();
		end
		check(16'(txQ.size()), 16'h0000);
		check(16'(frameGap), 16'(22 * TXD));
		$display("test transmit done");
		wr(ADR_CTL, 16'h0021);
		spk_printer_model_inst.press(c);
		repeat (2) @(posedge sys_clk);
		rd(ADR_CTL, st(3'h1, 4'h4));
		check(16'(piReq), 16'h0000);
		spk_printer_model_inst.land(c);
		repeat (2) @(posedge sys_clk);
		rd(ADR_CTL, st(3'h1, 4'h8));
		check(16'(piReq), 16'h0001);
		rd(ADR_DIN, {8'h00, c});
		rd(ADR_CTL, st(3'h1, 4'h0));
		rd(ADR_DIN, {8'h00, ~c});
		repeat (2) @(posedge sys_clk);
		$display("test receive done");
		wr(ADR_CTL, 16'h0556);
		rd(ADR_CTL, st(3'h6, 4'hf));
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(ADR_CTL, 16'h0000);
		check(16'(piReq), 16'h0000);
		repeat (2) @(posedge sys_clk);
		$display("test bus reset done");
		wrap_up();
	end
endmodule // spk_serial_ctrl_tb
